// File: core/mhdb_pkg.sv
// Package of register offsets, field positions and timing constants for the card host block.
package mhdb_pkg;
  localparam logic [7:0] REG_SYSCFG = 8'h00;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam int SYSCFG_IDLE_BIT = 0;
  localparam int DELAY_RESET_BIT = 31;
  localparam int STAT_CMD_DONE = 0;
  localparam int STAT_DATA_TIMEOUT = 1;
  localparam int STAT_DELAY_DONE = 2;
  localparam logic [5:0] CMD_BUS_TEST_WRITE = 6'h13;
  localparam logic [5:0] CMD_BUS_TEST_READ = 6'h0e;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DELAY_RESET_NS = 640;
  localparam int DELAY_RESET_CYCLES = (DELAY_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CRC_WAIT_LINK_EDGES = 8;
  localparam int CMD_BITS = 48;
  localparam logic [2:0] STAT_RESET = 3'h0;
  localparam logic [31:0] SYSCFG_RESET = 32'h0000_0001;
endpackage

// File: core/mhdb_link_if.sv
// Interface carrying link clock edge events between the host core and its link sampler.
`timescale 1ns/10ps
`default_nettype none
interface mhdb_link_if;
  logic rise;
  logic fall;
  logic dat0;
  modport sampler (output rise, output fall, output dat0);
  modport core (input rise, input fall, input dat0);
endinterface
`default_nettype wire

// File: core/mhdb_link_sampler.sv
// Link sampler that synchronises the card clock and data line and finds clock edges.
`timescale 1ns/10ps
`default_nettype none
module mhdb_link_sampler
  import mhdb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic link_dat0,
  mhdb_link_if.sampler lk
);
  logic [2:0] clk_sync;
  logic [2:0] dat_sync;
  logic clk_state;
  logic next_clk_state;
  logic dat_state;
  logic next_dat_state;

  // A change counts only once the second and third stages agree.
  always_comb
  begin
    next_clk_state = clk_state;
    next_dat_state = dat_state;
    if (clk_sync[1] == clk_sync[2])
      next_clk_state = clk_sync[2];
    if (dat_sync[1] == dat_sync[2])
      next_dat_state = dat_sync[2];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clk_sync <= 3'h0;
      dat_sync <= 3'h7;
      clk_state <= 1'b0;
      dat_state <= 1'b1;
    end
    else
    begin
      clk_sync <= {clk_sync[1:0], link_clk};
      dat_sync <= {dat_sync[1:0], link_dat0};
      clk_state <= next_clk_state;
      dat_state <= next_dat_state;
    end
  end

  assign lk.rise = next_clk_state & ~clk_state;
  assign lk.fall = ~next_clk_state & clk_state;
  assign lk.dat0 = dat_state;
endmodule
`default_nettype wire

// File: core/mhdb_host.sv
// Card host core: delay-line soft reset with idle gating and bus-test commands with data timeout.
// Operation
// - With the automatic idle bit set, the interface clock is gated so the delay-line done pulse is missed.
// - The delay-line reset still runs to its end, but its completion never reaches the registers while gated.
// - In the gated case the soft reset flag at bit 31 of the delay-line register stays at one.
// - While that flag is high, further software reset requests are ignored.
// - After the bus-test write command the controller waits for a write CRC status token.
// - When that token never comes, the controller raises its data timeout event flag.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module mhdb_host
  import mhdb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic link_clk,
  input wire logic link_cmd_in,
  output logic link_cmd_out,
  output logic link_cmd_oe,
  input wire logic link_dat0
);
  typedef enum {ST_IDLE, ST_SEND, ST_CRC_WAIT} mhdb_state_e;

  mhdb_link_if lk ();

  mhdb_link_sampler u_sampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .link_clk(link_clk),
    .link_dat0(link_dat0),
    .lk(lk)
  );

  logic [31:0] syscfg;
  logic [31:0] next_syscfg;
  logic soft_flag;
  logic next_soft_flag;
  logic dly_run;
  logic next_dly_run;
  logic [7:0] dly_cnt;
  logic [7:0] next_dly_cnt;
  logic [2:0] status;
  logic [2:0] next_status;
  logic [2:0] mask;
  logic [2:0] next_mask;
  logic [5:0] cmd_index;
  logic [5:0] next_cmd_index;
  mhdb_state_e state;
  mhdb_state_e next_state;
  logic [47:0] shift;
  logic [47:0] next_shift;
  logic [7:0] bit_cnt;
  logic [7:0] next_bit_cnt;
  logic [31:0] next_rdata;
  logic dly_done;
  logic cmd_done_ev;
  logic timeout_ev;
  logic cmd_out;
  logic next_cmd_out;
  logic cmd_oe;
  logic next_cmd_oe;
  logic done_captured;
  logic dly_request;
  logic cmd_accept;

  // Decode of a register address hit, shared by the read and write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // The run timer always reaches its end; only the capture of its done pulse is gated.
  assign dly_done = dly_run && (dly_cnt == 8'(DELAY_RESET_CYCLES - 1));

  // Qualified events shared by the sequencers and the register file, kept apart to avoid a loop.
  assign done_captured = dly_done && !syscfg[SYSCFG_IDLE_BIT];
  assign dly_request = wr_en && hit(addr, REG_DELAY) && wdata[DELAY_RESET_BIT];
  assign cmd_accept = wr_en && hit(addr, REG_CMD) && (state == ST_IDLE);

  // Delay-line reset sequencer; a request is refused while the flag is still high.
  always_comb
  begin
    next_soft_flag = soft_flag;
    next_dly_run = dly_run;
    next_dly_cnt = dly_cnt;
    if (dly_run)
    begin
      if (dly_done)
        next_dly_run = 1'b0;
      else
        next_dly_cnt = dly_cnt + 8'h01;
    end
    // With idle gating on, the done pulse is dropped and the flag stays set.
    if (done_captured)
      next_soft_flag = 1'b0;
    if (dly_request && !soft_flag)
    begin
      next_soft_flag = 1'b1;
      next_dly_run = 1'b1;
      next_dly_cnt = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      soft_flag <= 1'b0;
      dly_run <= 1'b0;
      dly_cnt <= 8'h00;
    end
    else
    begin
      soft_flag <= next_soft_flag;
      dly_run <= next_dly_run;
      dly_cnt <= next_dly_cnt;
    end
  end

  // Command engine: shifts the command out on link falling edges, then waits for CRC status after the bus-test write only.
  always_comb
  begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_cmd_out = cmd_out;
    next_cmd_oe = cmd_oe;
    cmd_done_ev = 1'b0;
    timeout_ev = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (cmd_accept)
        begin
          next_shift = {2'b01, wdata[5:0], wdata[31:0], 7'h00, 1'b1};
          next_bit_cnt = 8'h00;
          next_state = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (lk.fall)
        begin
          next_cmd_oe = 1'b1;
          next_cmd_out = shift[47];
          next_shift = {shift[46:0], 1'b1};
          if (bit_cnt == 8'(CMD_BITS))
          begin
            next_cmd_oe = 1'b0;
            next_cmd_out = 1'b1;
            cmd_done_ev = 1'b1;
            next_bit_cnt = 8'h00;
            // The write bus-test command wrongly expects a CRC status token afterwards.
            if (cmd_index == CMD_BUS_TEST_WRITE)
              next_state = ST_CRC_WAIT;
            else
              next_state = ST_IDLE;
          end
          else
            next_bit_cnt = bit_cnt + 8'h01;
        end
      end
      ST_CRC_WAIT:
      begin
        // A token start bit would end the wait; the card sends none for bus test.
        if (lk.rise && !lk.dat0)
          next_state = ST_IDLE;
        else if (lk.rise)
        begin
          if (bit_cnt == 8'(CRC_WAIT_LINK_EDGES - 1))
          begin
            timeout_ev = 1'b1;
            next_state = ST_IDLE;
          end
          else
            next_bit_cnt = bit_cnt + 8'h01;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      shift <= 48'h0;
      bit_cnt <= 8'h00;
      cmd_out <= 1'b1;
      cmd_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      cmd_out <= next_cmd_out;
      cmd_oe <= next_cmd_oe;
    end
  end

  // Configuration writes; the command index only follows a command the engine accepts.
  always_comb
  begin
    next_syscfg = syscfg;
    next_mask = mask;
    next_cmd_index = cmd_index;
    if (wr_en && hit(addr, REG_SYSCFG))
      next_syscfg = {31'h0, wdata[SYSCFG_IDLE_BIT]};
    if (wr_en && hit(addr, REG_MASK))
      next_mask = wdata[2:0];
    if (cmd_accept)
      next_cmd_index = wdata[5:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syscfg <= SYSCFG_RESET;
      mask <= 3'h0;
      cmd_index <= 6'h00;
    end
    else
    begin
      syscfg <= next_syscfg;
      mask <= next_mask;
      cmd_index <= next_cmd_index;
    end
  end

  // Sticky event bits; a read clears them, but an event in the same cycle wins so none is lost.
  always_comb
  begin
    next_status = status;
    if (rd_en && hit(addr, REG_STATUS))
      next_status = STAT_RESET;
    if (cmd_done_ev)
      next_status[STAT_CMD_DONE] = 1'b1;
    if (timeout_ev)
      next_status[STAT_DATA_TIMEOUT] = 1'b1;
    if (done_captured)
      next_status[STAT_DELAY_DONE] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      status <= STAT_RESET;
    else
      status <= next_status;
  end

  // Read path; the word stands in the cycle after the strobe and is zero otherwise.
  always_comb
  begin
    next_rdata = 32'h0;
    if (rd_en)
    begin
      if (hit(addr, REG_SYSCFG))
        next_rdata = syscfg;
      else if (hit(addr, REG_DELAY))
        next_rdata = {soft_flag, 30'h0, dly_run};
      else if (hit(addr, REG_CMD))
        next_rdata = {24'h0, state != ST_IDLE, 1'b0, cmd_index};
      else if (hit(addr, REG_STATUS))
        next_rdata = {29'h0, status};
      else if (hit(addr, REG_MASK))
        next_rdata = {29'h0, mask};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

  assign irq = |(status & mask);
  assign link_cmd_out = cmd_out;
  assign link_cmd_oe = cmd_oe;

  // The response line is not decoded here; only data timeout matters for bus test.
  logic unused_cmd_in;
  assign unused_cmd_in = link_cmd_in;
endmodule
`default_nettype wire

// File: bench/mhdb_host_chk.sv
// Checker for the delay-line reset and bus-test timeout seen at the host ports.
`timescale 1ns/10ps
`default_nettype none
module mhdb_host_chk
  import mhdb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic link_cmd_oe,
  input wire logic link_dat0
);
  logic idle, lr, stk;
  logic [2:0] mk;
  logic [5:0] ix;
  wire st = wr_en && addr == REG_DELAY && wdata[31];
  wire rdl = rd_en && addr == REG_DELAY;
  wire tw = ix == CMD_BUS_TEST_WRITE;
  // Shadows of idle, mask and command; a flag seen high with no run going is stuck.
  always_ff @(posedge clk)
  begin
    idle <= sys_rst ? 1'b1 : wr_en && addr == REG_SYSCFG ? wdata[0] : idle;
    mk <= sys_rst ? 3'h0 : wr_en && addr == REG_MASK ? wdata[2:0] : mk;
    ix <= wr_en && addr == REG_CMD ? wdata[5:0] : ix;
    lr <= rdl;
    stk <= !sys_rst && (stk || lr && rdata[31] && !rdata[0]);
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  stuck_flag_a: assert property (st && idle ##23 rdl |=> rdata[31]) else $error("flag fell");
  no_done_a: assert property (st && idle ##23 rdl ##2 rd_en && addr == REG_STATUS |=> !rdata[2]) else $error("done");
  ignored_req_a: assert property (st && stk ##2 rdl |=> !rdata[0]) else $error("run restarted");
  self_clear_a: assert property (st && !idle && !stk ##23 rdl |=> !rdata[31]) else $error("flag held");
  done_irq_a: assert property (st && !idle && !stk && mk == 3'h4 |-> ##[12:22] irq) else $error("no irq");
  crc_wait_a: assert property ($fell(link_cmd_oe) && tw && mk == 3'h2 && !link_dat0 |-> ##90 !irq) else $error("irq");
  timeout_a: assert property ($fell(link_cmd_oe) && tw && mk == 3'h2 && link_dat0 && !irq |-> ##[40:90] irq) else $error("none");
  cover property (st && idle);
  cover property ($rose(irq));
  cover property ($fell(link_cmd_oe) && tw);
endmodule
`default_nettype wire

// File: bench/mhdb_card_model.sv
// Card model: link clock while run is high, command capture and the data line.
`timescale 1ns/10ps
`default_nettype none
module mhdb_card_model
(
  input wire logic run,
  input wire logic tok,
  input wire logic link_cmd_out,
  input wire logic link_cmd_oe,
  output logic link_clk,
  output logic link_dat0,
  output logic [47:0] frame
);
  // The clock rests while run is low so nothing can lean on a free-running edge.
  initial
  begin
    link_clk = 1'b0;
    forever #160 if (run) link_clk = ~link_clk;
  end
  // The card samples the command line on rising edges while the host drives it.
  always @(posedge link_clk) if (link_cmd_oe) frame <= {frame[46:0], link_cmd_out};
  // Pulled up; a card that answers pulls it low once the command is over.
  assign link_dat0 = !(tok && !link_cmd_oe);
endmodule
`default_nettype wire

// File: bench/tb.sv
// Testbench for the card host: delay-line reset under idle gating and the bus-test pair.
`timescale 1ns/10ps
`default_nettype none
module tb
  import mhdb_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic run = 1'b0;
  logic tok = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [47:0] frame;
  logic irq, link_clk, link_cmd_out, link_cmd_oe, link_dat0;
  int n_mismatch = 0;
  int n_compared = 0;
  // The command line is pulled up whenever the host lets go of it.
  wire lci = link_cmd_oe ? link_cmd_out : 1'b1;
  // System clock, 40 ns period.
  always #20 clk = ~clk;
  mhdb_host mhdb_host_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .irq(irq),
    .link_clk(link_clk),
    .link_cmd_in(lci),
    .link_cmd_out(link_cmd_out),
    .link_cmd_oe(link_cmd_oe),
    .link_dat0(link_dat0)
  );
  mhdb_card_model mhdb_card_model_i (
    .run(run),
    .tok(tok),
    .link_cmd_out(link_cmd_out),
    .link_cmd_oe(link_cmd_oe),
    .link_clk(link_clk),
    .link_dat0(link_dat0),
    .frame(frame)
  );
  task automatic chk(input string what, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(what, rdata, e);
  endtask
  task automatic dly(input logic [31:0] ef, input logic [31:0] es);
    wr(REG_DELAY, 32'h8000_0000);
    repeat (21) @(posedge clk);
    rc(REG_DELAY, ef, "delay flag");
    chk("irq", {31'h0, irq}, {31'h0, es[2]});
    rc(REG_STATUS, es, "status");
    chk("irq clear", {31'h0, irq}, 32'h0);
  endtask
  task automatic cmd(input logic [5:0] c, input logic [31:0] es);
    wr(REG_CMD, {26'h0, c});
    for (int i = 0; i < 100 && !link_cmd_oe; i++) @(posedge clk);
    rc(REG_CMD, {24'h0, 1'b1, 1'b0, c}, "cmd busy");
    for (int i = 0; i < 600 && link_cmd_oe; i++) @(posedge clk);
    chk("frame", {frame[47:40], 23'h0, frame[0]}, {2'b01, c, 23'h0, 1'b1});
    for (int i = 0; i < 100 && !irq; i++) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, es[1]});
    rc(REG_STATUS, es, "status");
    chk("irq clear", {31'h0, irq}, 32'h0);
    rc(REG_CMD, {26'h0, c}, "cmd index");
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A hang is cut short well after the roughly 1600 cycles the tests need.
  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end
  // Main sequence of tests.
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rc(REG_SYSCFG, SYSCFG_RESET, "syscfg");
    rc(REG_DELAY, 32'h0, "delay");
    rc(REG_STATUS, {29'h0, STAT_RESET}, "status");
    rc(8'h14, 32'h0, "unmapped");
    $display("test reset done");
    dly(32'h8000_0000, 32'h0);
    wr(REG_SYSCFG, 32'h0);
    wr(REG_DELAY, 32'h8000_0000);
    rc(REG_DELAY, 32'h8000_0000, "ignored");
    $display("test gated done");
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rc(REG_DELAY, 32'h0, "delay");
    wr(REG_MASK, 32'h4);
    wr(REG_SYSCFG, 32'h0);
    dly(32'h0, 32'h4);
    wr(REG_SYSCFG, 32'h1);
    rc(REG_SYSCFG, 32'h1, "syscfg");
    $display("test ungated done");
    run <= 1'b1;
    wr(REG_MASK, 32'h2);
    rc(REG_MASK, 32'h2, "mask");
    cmd(CMD_BUS_TEST_WRITE, 32'h3);
    cmd(CMD_BUS_TEST_READ, 32'h1);
    tok <= 1'b1;
    cmd(CMD_BUS_TEST_WRITE, 32'h1);
    run <= 1'b0;
    $display("test bus done");
    final_report();
  end
endmodule
bind mhdb_host mhdb_host_chk mhdb_host_chk_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .addr(addr),
  .wdata(wdata),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rdata(rdata),
  .irq(irq),
  .link_cmd_oe(link_cmd_oe),
  .link_dat0(link_dat0)
);
`default_nettype wire
